// file: hw/pcbar_bank.sv
// Functional notes
// - The bank is meant for a bus clock of at most 66 MHz.
// - Status bit 5 reads set only when the fast-clock option is on.
// - Identity, revision, subsystem, grant, latency and class registers are read-only.
// - Up to six 32-bit base windows plus one expansion ROM window, count set at build.
// - A 64-bit window may pair windows one and zero, or two and one.
// - A build with no base window enabled is refused.
// - Enabled windows sit consecutively from window zero.
// - By default window zero is on and decodes one megabyte of memory.
// - A non-hardwired window stores the address software writes and decodes on it.
// - A hardwired window ignores writes and returns its parameter.
// - A hardwired window returns the parameter on all bits, attribute bits included.
// - The upper half of a 64-bit window has 8 to 32 writable bits.
`include "pcbar_map.svh"
module pcbar_bank
   import pcbar_pkg::*;
#(
   parameter int BUS_MHZ = `PCBAR_CLK_MHZ,
   parameter bit FAST_CLOCK_CAPABLE_OPTION = 1'b0,
   parameter logic [15:0] VENDOR_CODE = 16'h0000, // Arbitrary identity value
   parameter logic [15:0] DEVICE_CODE = 16'h0000, // Arbitrary identity value
   parameter logic [7:0] REVISION_CODE = 8'h00,   // Arbitrary identity value
   parameter logic [15:0] SUBSYS_VENDOR_CODE = 16'h0000, // Arbitrary identity value
   parameter logic [15:0] SUBSYS_CODE = 16'h0000, // Arbitrary identity value
   parameter logic [23:0] CLASS_CODE = 24'hFF_0000,
   parameter logic [7:0] MIN_GRANT = 8'h00,
   parameter logic [7:0] MAX_LATENCY = 8'h00,
   parameter int NUM_WINDOWS = 1,
   parameter pcbar_pair_t PAIRING = PCBAR_PAIR_NONE,
   parameter int UPPER_BITS = 32,
   parameter logic [5:0][31:0] WINDOW_MASK = {{5{32'h0000_0000}}, `PCBAR_DEF_MASK0},
   parameter logic [5:0][3:0] WINDOW_ATTR = '0,
   parameter logic [5:0] HARDWIRED = '0,
   parameter logic [5:0][31:0] HARDWIRED_VALUE = '0,
   parameter bit ROM_ENABLE = 1'b0,
   parameter logic [31:0] ROM_MASK = 32'hFFFF_0000,
   parameter bit ROM_HARDWIRED = 1'b0,
   parameter logic [31:0] ROM_HARDWIRED_VALUE = 32'h0000_0000
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic [7:0] CFG_ADDR_I,
   input wire logic [31:0] CFG_WDATA_I,
   input wire logic CFG_WR_I,
   input wire logic CFG_RD_I,
   output logic [31:0] CFG_RDATA_O,
   input wire logic [63:0] ACCESS_ADDR_I,
   output logic [5:0] WINDOW_HIT_O,
   output logic ROM_HIT_O
);
   localparam int LOWER_OF_PAIR = (PAIRING == PCBAR_PAIR_21) ? 1 : 0;

   // Build checks
   initial begin
      if (BUS_MHZ > `PCBAR_FAST_MHZ) $error("Bus clock above supported rate");
      if (NUM_WINDOWS < 1 || NUM_WINDOWS > `PCBAR_WIN_COUNT)
         $error("Window count out of range");
      if (UPPER_BITS < `PCBAR_UPPER_MIN || UPPER_BITS > `PCBAR_UPPER_MAX)
         $error("Upper writable width out of range");
      if (PAIRING != PCBAR_PAIR_NONE && NUM_WINDOWS < LOWER_OF_PAIR + 2)
         $error("Paired window not enabled");
   end

   function automatic logic is_upper(input int idx);
      return (PAIRING != PCBAR_PAIR_NONE) && (idx == LOWER_OF_PAIR + 1);
   endfunction

   function automatic logic [31:0] eff_mask(input int idx);
      logic [31:0] m;
      m = '0;
      if (idx < NUM_WINDOWS) begin
         if (is_upper(idx)) begin
            m = (UPPER_BITS == 32) ? 32'hFFFF_FFFF :
               ((32'h0000_0001 << UPPER_BITS) - 32'h0000_0001);
         end else begin
            m = WINDOW_MASK[idx] & ~32'h0000_000F;
         end
      end
      return m;
   endfunction

   function automatic logic [31:0] attr_bits(input int idx);
      logic [31:0] a;
      a = '0;
      if (idx < NUM_WINDOWS && !is_upper(idx)) begin
         a[3:0] = WINDOW_ATTR[idx];
         if (PAIRING != PCBAR_PAIR_NONE && idx == LOWER_OF_PAIR) begin
            a[3:0] = WINDOW_ATTR[idx] | `PCBAR_ATTR_MEM64;
         end
      end
      return a;
   endfunction

   pcbar_req_t req;
   pcbar_state_t st, next_st;
   logic [31:0] win_value [6];
   logic [31:0] rom_value;
   logic [31:0] stat_word;

   assign req = '{addr: CFG_ADDR_I, wdata: CFG_WDATA_I, wr: CFG_WR_I, rd: CFG_RD_I};
   assign stat_word = FAST_CLOCK_CAPABLE_OPTION ?
      (32'h0000_0001 << `PCBAR_STAT_FAST_BIT) : 32'h0000_0000;

   always_comb begin
      for (int i = 0; i < `PCBAR_WIN_COUNT; i++) begin
         if (HARDWIRED[i] && i < NUM_WINDOWS) begin
            win_value[i] = HARDWIRED_VALUE[i];
         end else begin
            win_value[i] = (st.win[i] & eff_mask(i)) | attr_bits(i);
         end
      end
      if (!ROM_ENABLE) begin
         rom_value = '0;
      end else if (ROM_HARDWIRED) begin
         rom_value = ROM_HARDWIRED_VALUE;
      end else begin
         rom_value = (st.rom & ROM_MASK) | {31'h0000_0000, st.rom[0]};
      end
   end

   always_comb begin
      next_st = st;
      next_st.rdata = '0;
      if (req.wr) begin
         for (int i = 0; i < `PCBAR_WIN_COUNT; i++) begin
            // Hardwired windows and identity words have no write path
            if (req.addr == `PCBAR_OFS_WIN0 + 8'(4 * i) && !HARDWIRED[i]) begin
               next_st.win[i] = req.wdata & eff_mask(i);
            end
         end
         if (req.addr == `PCBAR_OFS_ROM && !ROM_HARDWIRED) begin
            next_st.rom = req.wdata & (ROM_MASK | 32'h0000_0001);
         end
      end
      if (req.rd) begin
         if (req.addr == `PCBAR_OFS_ID) begin
            next_st.rdata = {DEVICE_CODE, VENDOR_CODE};
         end else if (req.addr == `PCBAR_OFS_STATCMD) begin
            next_st.rdata = stat_word;
         end else if (req.addr == `PCBAR_OFS_CLASSREV) begin
            next_st.rdata = {CLASS_CODE, REVISION_CODE};
         end else if (req.addr == `PCBAR_OFS_SUBSYS) begin
            next_st.rdata = {SUBSYS_CODE, SUBSYS_VENDOR_CODE};
         end else if (req.addr == `PCBAR_OFS_ROM) begin
            next_st.rdata = rom_value;
         end else if (req.addr == `PCBAR_OFS_LATGNT) begin
            next_st.rdata = {MAX_LATENCY, MIN_GRANT, 16'h0000};
         end else begin
            for (int i = 0; i < `PCBAR_WIN_COUNT; i++) begin
               if (req.addr == `PCBAR_OFS_WIN0 + 8'(4 * i)) begin
                  next_st.rdata = win_value[i];
               end
            end
         end
      end
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (RST_I) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign CFG_RDATA_O = st.rdata;

   // Decode; the paired lower window compares both halves
   genvar g;
   generate
      for (g = 0; g < `PCBAR_WIN_COUNT; g++) begin : g_dec
         // Wrapped index keeps the last window's unused pair lookup in range
         localparam int NXT = (g + 1) % `PCBAR_WIN_COUNT;
         logic [63:0] base64, mask64;
         always_comb begin
            if (PAIRING != PCBAR_PAIR_NONE && g == LOWER_OF_PAIR) begin
               base64 = {win_value[NXT], win_value[g]};
               mask64 = {eff_mask(NXT), eff_mask(g)};
            end else begin
               base64 = {32'h0000_0000, win_value[g]};
               mask64 = {32'hFFFF_FFFF, eff_mask(g)};
            end
         end
         pcbar_match #(.WIDTH(64)) u_match (
            .base_i(base64),
            .mask_i(mask64),
            .addr_i(ACCESS_ADDR_I),
            .enable_i((g < NUM_WINDOWS) && !is_upper(g) && (eff_mask(g) != '0)),
            .hit_o(WINDOW_HIT_O[g])
         );
      end
   endgenerate

   pcbar_match #(.WIDTH(64)) u_rom_match (
      .base_i({32'h0000_0000, rom_value}),
      .mask_i({32'hFFFF_FFFF, ROM_MASK}),
      .addr_i(ACCESS_ADDR_I),
      .enable_i(ROM_ENABLE && rom_value[0]),
      .hit_o(ROM_HIT_O)
   );
endmodule

// file: hw/pcbar_match.sv
`include "pcbar_map.svh"
module pcbar_match
   import pcbar_pkg::*;
#(
   parameter int WIDTH = 32
) (
   input wire logic [WIDTH-1:0] base_i,
   input wire logic [WIDTH-1:0] mask_i,
   input wire logic [WIDTH-1:0] addr_i,
   input wire logic enable_i,
   output logic hit_o
);
   // Only bits the mask marks writable take part in the compare
   assign hit_o = enable_i && (((base_i ^ addr_i) & mask_i) == '0);
endmodule

// file: shared/pcbar_map.svh
`ifndef PCBAR_MAP_SVH
`define PCBAR_MAP_SVH
// Configuration space byte offsets
`define PCBAR_OFS_ID 8'h00
`define PCBAR_OFS_STATCMD 8'h04
`define PCBAR_OFS_CLASSREV 8'h08
`define PCBAR_OFS_WIN0 8'h10
`define PCBAR_OFS_ROM 8'h30
`define PCBAR_OFS_SUBSYS 8'h2C
`define PCBAR_OFS_LATGNT 8'h3C
// Field positions and values, counts, limits and clock rates
`define PCBAR_STAT_FAST_BIT 21
`define PCBAR_ATTR_BITS 4
`define PCBAR_ATTR_MEM64 4'h4
`define PCBAR_ROM_LOW_BITS 11
`define PCBAR_WIN_COUNT 6
`define PCBAR_UPPER_MIN 8
`define PCBAR_UPPER_MAX 32
`define PCBAR_DEF_MASK0 32'hFFF0_0000
`define PCBAR_FAST_MHZ 66
`define PCBAR_CLK_MHZ 25
`endif

// file: shared/pcbar_pkg.sv
package pcbar_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pcbar_req_t;

   typedef struct packed {
      logic [5:0][31:0] win;
      logic [31:0] rom;
      logic [31:0] rdata;
   } pcbar_state_t;

   typedef enum logic [1:0] {
      PCBAR_PAIR_NONE = 2'b01,
      PCBAR_PAIR_10 = 2'b10,
      PCBAR_PAIR_21 = 2'b11
   } pcbar_pair_t;
endpackage

// file: tb/pcbar_bank_chk.sv
`include "pcbar_map.svh"
module pcbar_bank_chk
   import pcbar_pkg::*;
#(
   parameter bit FAST = 1'b0,
   parameter logic [23:0] CLASS_CODE = 24'h00_0000,
   parameter logic [7:0] REVISION_CODE = 8'h00,
   parameter int NUM_WINDOWS = 1,
   parameter pcbar_pair_t PAIRING = PCBAR_PAIR_NONE,
   parameter int UPPER_BITS = 32,
   parameter logic [31:0] MASK0 = 32'hFFF0_0000,
   parameter bit HW2 = 1'b0,
   parameter logic [31:0] HWV2 = 32'h0000_0000,
   parameter bit ROM_ENABLE = 1'b0
) (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic [7:0] CFG_ADDR_I,
   input wire logic CFG_RD_I,
   input wire logic [31:0] CFG_RDATA_O,
   input wire logic [5:0] WINDOW_HIT_O,
   input wire logic ROM_HIT_O
);
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   sequence s_rd(logic [7:0] a);
      CFG_RD_I && CFG_ADDR_I == a;
   endsequence
   a_fast_bit: assert property (s_rd(`PCBAR_OFS_STATCMD) |=>
      CFG_RDATA_O[`PCBAR_STAT_FAST_BIT] == FAST)
      else $error("fast capable bit wrong");
   a_class_fixed: assert property (s_rd(`PCBAR_OFS_CLASSREV) |=>
      CFG_RDATA_O == {CLASS_CODE, REVISION_CODE})
      else $error("class or revision wrong");
   a_unmapped_zero: assert property (s_rd(8'h40) |=> CFG_RDATA_O == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_rom_off: assert property (!ROM_ENABLE |-> !ROM_HIT_O)
      else $error("rom hit while absent");
   a_pair_attr: assert property ((PAIRING == PCBAR_PAIR_10) ##0 s_rd(`PCBAR_OFS_WIN0) |=>
      CFG_RDATA_O[3:0] == `PCBAR_ATTR_MEM64)
      else $error("pair attribute wrong");
   a_pair_hit_low: assert property (PAIRING == PCBAR_PAIR_10 |-> !WINDOW_HIT_O[1])
      else $error("upper half of pair hit");
   a_unused_off: assert property ((WINDOW_HIT_O >> NUM_WINDOWS) == 6'h0)
      else $error("disabled window hit");
   a_size_mask: assert property (s_rd(`PCBAR_OFS_WIN0) |=>
      (CFG_RDATA_O[31:4] & ~MASK0[31:4]) == 28'h0)
      else $error("window size bits writable");
   a_hard_value: assert property (HW2 ##0 s_rd(8'h18) |=> CFG_RDATA_O == HWV2)
      else $error("hardwired value wrong");
   a_upper_zero: assert property ((PAIRING == PCBAR_PAIR_10) ##0 s_rd(8'h14) |=>
      (CFG_RDATA_O >> UPPER_BITS) == 32'h0000_0000)
      else $error("upper bits above count set");
endmodule
bind pcbar_bank pcbar_bank_chk #(.FAST(FAST_CLOCK_CAPABLE_OPTION), .CLASS_CODE(CLASS_CODE),
   .REVISION_CODE(REVISION_CODE), .NUM_WINDOWS(NUM_WINDOWS), .PAIRING(PAIRING),
   .UPPER_BITS(UPPER_BITS), .MASK0(WINDOW_MASK[0]), .HW2(HARDWIRED[2]),
   .HWV2(HARDWIRED_VALUE[2]), .ROM_ENABLE(ROM_ENABLE)) chk (.CORE_CLK_I(CORE_CLK_I),
   .RST_I(RST_I), .CFG_ADDR_I(CFG_ADDR_I), .CFG_RD_I(CFG_RD_I), .CFG_RDATA_O(CFG_RDATA_O),
   .WINDOW_HIT_O(WINDOW_HIT_O), .ROM_HIT_O(ROM_HIT_O));

// file: tb/pcbar_bank_tb_top.sv
module pcbar_bank_tb_top;
   import pcbar_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] HW = 32'h8000_000C;
   logic clk, rst, wr, rd, rom;
   logic [7:0] addr, addr_sel;
   logic [31:0] wd, rdata, d, lo, hi, seed;
   logic [63:0] acc;
   logic [5:0] hit;
   int fail_count, num_checks, cyc;
   pcbar_bank #(.FAST_CLOCK_CAPABLE_OPTION(1'b1), .NUM_WINDOWS(3), .PAIRING(PCBAR_PAIR_10),
      .UPPER_BITS(8), .HARDWIRED(6'h04), .HARDWIRED_VALUE({96'h0, HW, 64'h0})) dut (
      .CORE_CLK_I(clk), .RST_I(rst), .CFG_ADDR_I(addr), .CFG_WDATA_I(wd), .CFG_WR_I(wr),
      .CFG_RD_I(rd), .CFG_RDATA_O(rdata), .ACCESS_ADDR_I(acc), .WINDOW_HIT_O(hit),
      .ROM_HIT_O(rom));
   pcbar_host host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wd), .wr_o(wr),
      .rd_o(rd));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Identity words come from the default build values
   function automatic logic [31:0] exp_id(logic [7:0] a);
      return (a == 8'h08) ? 32'hFF00_0000 : 32'h0000_0000;
   endfunction
   function automatic logic [31:0] exp_lo(logic [31:0] x);
      return (x & 32'hFFF0_0000) | 32'h0000_0004;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Ceiling far above the roughly one hundred cycles the tests take
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         fail_count++;
         end_sim();
      end
   end
   initial begin
      rst = 1'b1;
      acc = '0;
      seed = 32'h0000_2CD8;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         addr_sel = i == 0 ? 8'h00 : i == 1 ? 8'h08 : i == 2 ? 8'h2C : 8'h3C;
         host.rd(addr_sel, d);
         chk(d, exp_id(addr_sel));
         host.wr(addr_sel, 32'hFFFF_FFFF);
         host.rd(addr_sel, d);
         chk(d, exp_id(addr_sel));
      end
      host.rd(8'h04, d);
      chk(d, 32'h0020_0000);
      $display("test identity done");
      for (int i = 0; i < 6; i++) begin
         lo = i == 0 ? 32'hFFFF_FFFF : i == 1 ? 32'h0000_0000 : rnd();
         hi = i == 0 ? 32'hFFFF_FFFF : rnd();
         host.wr(8'h10, lo);
         host.wr(8'h14, hi);
         host.rd(8'h10, d);
         chk(d, exp_lo(lo));
         host.rd(8'h14, d);
         chk(d, hi & 32'h0000_00FF);
      end
      // Bits above the upper count must not matter to the decode
      acc <= {hi ^ 32'hFF00_0000, exp_lo(lo) ^ (rnd() & 32'h000F_FFF0)};
      @(posedge clk);
      @(posedge clk);
      chk(32'(hit), 32'h0000_0001);
      chk(32'(rom), 32'h0000_0000);
      acc[32] <= ~acc[32];
      @(posedge clk);
      @(posedge clk);
      chk(32'(hit), 32'h0000_0000);
      $display("test decode done");
      host.wr(8'h18, 32'h0000_0000);
      host.rd(8'h18, d);
      chk(d, HW);
      host.rd(8'h40, d);
      chk(d, 32'h0000_0000);
      $display("test hardwired done");
      end_sim();
   end
endmodule

// file: tb/pcbar_host.sv
module pcbar_host (
   input wire logic clk_i,
   input wire logic [31:0] rdata_i,
   output logic [7:0] addr_o,
   output logic [31:0] wdata_o,
   output logic wr_o,
   output logic rd_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {addr_o, wdata_o, wr_o, rd_o} = '0;
   end
   // Extra edge keeps back-to-back calls from reassigning a strobe
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      // Data stand only in the cycle after the strobe; take them mid-cycle
      @(negedge clk_i);
      d = rdata_i;
      @(posedge clk_i);
   endtask
endmodule
